/* host_bus_model.sv */
// Host model that drives the register port
module host_bus_model (
    // Clock
    input  wire logic        i_ref_clk,
    // Register port
    input  wire logic [31:0] i_rdata,
    output logic [7:0]       o_addr,
    output logic [31:0]      o_wdata,
    output logic             o_wr,
    output logic             o_rd
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_addr = 8'h00;
        o_wdata = 32'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_ref_clk);
        o_wr <= 1'b0;
    endtask : wr

    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_ref_clk);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask : rd
endmodule : host_bus_model

/* interval_timer.sv */
// Down counter that expires after a loaded number of ticks
module interval_timer #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_resetn,
    // Control
    input  wire logic             i_load,
    input  wire logic [WIDTH-1:0] i_value,
    input  wire logic             i_stop,
    input  wire logic             i_tick,
    // Status
    output logic                  o_armed,
    output logic                  o_expired
);

    logic [WIDTH-1:0] count;
    wire              last_tick = o_armed && i_tick && (count <= 1);

    // Load wins over stop so a restart is never lost
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            count     <= '0;
            o_armed   <= 1'b0;
            o_expired <= 1'b0;
        end else begin
            o_expired <= last_tick && !i_load && !i_stop;
            if (i_load) begin
                count   <= i_value;
                o_armed <= 1'b1;
            end else if (i_stop || last_tick) begin
                count   <= '0;
                o_armed <= 1'b0;
            end else if (o_armed && i_tick) begin
                count   <= count - 1'b1;
            end
        end
    end

endmodule : interval_timer

/* sleep_ctrl_pkg.sv */
// Constants, types and register map of the sleep mode controller
// Overview of operation
// - Sleep mode select takes codes 0 to 6; larger writes are ignored.
// - After reset sleep mode is disabled and the block stays awake.
// - Option bit 0 clear polls on cyclic wake-up; set skips the poll.
// - Option bit 1 clear samples on wake when sampling enabled; set skips it.
// - Cyclic sleep wakes at period end, checks data, sleeps again if idle.
// - Cyclic sleep period counts 10 ms units, 0 to 0x68b0.
// - Sleep period only acts in modes 4 to 6, otherwise ignored.
// - Coordinator with nonzero period discards held message after 2.5 periods.
// - Sleep only after idle time, 1 to 0xffff in 1 ms units.
// - Idle time before sleep only acts in cyclic modes 4 and 5.
package sleep_ctrl_pkg;

    // Register port
    localparam int          ADDR_W             = 8;
    localparam int          DATA_W             = 32;
    localparam logic [7:0]  REG_SLEEP_MODE     = 8'h00;
    localparam logic [7:0]  REG_SLEEP_OPTIONS  = 8'h04;
    localparam logic [7:0]  REG_CYCLIC_PERIOD  = 8'h08;
    localparam logic [7:0]  REG_IDLE_TIME      = 8'h0c;
    localparam logic [7:0]  REG_CONTROL        = 8'h10;
    localparam logic [7:0]  REG_STATUS         = 8'h14;

    // Reset values
    localparam logic [2:0]  SLEEP_MODE_RST     = 3'h0;
    localparam logic [1:0]  OPTIONS_RST        = 2'h0;
    localparam logic [15:0] PERIOD_RST         = 16'h0000;
    localparam logic [15:0] IDLE_TIME_RST      = 16'h03e8;
    localparam logic [1:0]  CONTROL_RST        = 2'h0;

    // Ranges
    localparam logic [2:0]  MODE_MAX           = 3'h6;
    localparam logic [15:0] PERIOD_MAX         = 16'h68b0;
    localparam logic [15:0] IDLE_TIME_MIN      = 16'h0001;

    // Field positions
    localparam int          OPT_POLL_DIS_BIT   = 0;
    localparam int          OPT_SAMPLE_DIS_BIT = 1;
    localparam int          CTRL_SAMPLE_EN_BIT = 0;
    localparam int          CTRL_COORD_EN_BIT  = 1;
    localparam int          STAT_STATE_LSB     = 0;
    localparam int          STAT_HELD_BIT      = 4;
    localparam int          STAT_COORD_BIT     = 5;
    localparam int          STAT_PIN_BIT       = 6;

    // Timing
    localparam int          CLK_PERIOD_PS      = 8000;
    localparam int          IDLE_UNIT_MS       = 1;
    localparam int          PERIOD_UNIT_MS     = 10;
    localparam int          HOLD_FACTOR_X10    = 25;
    localparam int          MS_CYCLES          =
        IDLE_UNIT_MS * 1000000000 / CLK_PERIOD_PS;
    localparam int          MS_PER_PERIOD      = PERIOD_UNIT_MS / IDLE_UNIT_MS;
    localparam int          HOLD_MS_PER_UNIT   =
        PERIOD_UNIT_MS * HOLD_FACTOR_X10 / 10;
    localparam int          HOLD_W             = 20;

    typedef enum logic [2:0] {
        MODE_DISABLED      = 3'h0,
        MODE_PIN_HIBERNATE = 3'h1,
        MODE_PIN_DOZE      = 3'h2,
        MODE_RESERVED      = 3'h3,
        MODE_CYCLIC        = 3'h4,
        MODE_CYCLIC_PIN    = 3'h5,
        MODE_COORDINATOR   = 3'h6
    } sleep_mode_t;

    typedef enum logic [1:0] {
        PS_AWAKE  = 2'h0,
        PS_ASLEEP = 2'h1,
        PS_WAKING = 2'h2
    } power_state_t;

    typedef struct packed {
        logic [2:0]  sleep_mode_select;
        logic        poll_dis;
        logic        sample_dis;
        logic [15:0] cyclic_sleep_period;
        logic [15:0] idle_time_before_sleep;
        logic        coord_en;
        logic        sample_en;
    } sleep_cfg_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_t;

endpackage : sleep_ctrl_pkg

/* sleep_mode_controller.sv */
// Sleep mode controller: registers, sleep state machine and timers
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
module sleep_mode_controller #(
    parameter int MS_CYCLES = sleep_ctrl_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    // Register port
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic [31:0]      o_reg_rdata,
    // Activity from the serial and radio logic
    input  wire logic        i_serial_activity,
    input  wire logic        i_rf_activity,
    input  wire logic        i_data_pending,
    // Sleep request pin, asynchronous
    input  wire logic        i_sleep_pin,
    // Indirect message queue
    input  wire logic        i_msg_queued,
    input  wire logic        i_msg_delivered,
    // Power outputs
    output logic             o_sleep,
    output logic             o_deep_sleep,
    output logic             o_poll_req,
    output logic             o_sample_req,
    output logic             o_msg_held,
    output logic             o_msg_discard
);

    sleep_ctrl_pkg::reg_req_t     req;
    sleep_ctrl_pkg::sleep_cfg_t   cfg;
    sleep_ctrl_pkg::power_state_t state;
    sleep_ctrl_pkg::power_state_t next_state;
    logic                         pin_meta;
    logic                         pin_sync;
    logic                         ms_armed;
    logic                         ms_tick;
    logic                         ten_armed;
    logic                         ten_tick;
    logic                         idle_armed;
    logic                         idle_done;
    logic                         period_armed;
    logic                         period_done;
    logic                         hold_armed;
    logic                         hold_done;
    logic [31:0]                  rd_word;

    assign req = '{wr: i_reg_wr, rd: i_reg_rd, addr: i_reg_addr,
                   wdata: i_reg_wdata};

    // Address decode
    wire sel_mode    = req.addr == sleep_ctrl_pkg::REG_SLEEP_MODE;
    wire sel_opts    = req.addr == sleep_ctrl_pkg::REG_SLEEP_OPTIONS;
    wire sel_period  = req.addr == sleep_ctrl_pkg::REG_CYCLIC_PERIOD;
    wire sel_idle    = req.addr == sleep_ctrl_pkg::REG_IDLE_TIME;
    wire sel_ctrl    = req.addr == sleep_ctrl_pkg::REG_CONTROL;
    wire sel_status  = req.addr == sleep_ctrl_pkg::REG_STATUS;

    wire mode_ok     = (req.wdata[31:3] == 29'h0)
                    && (req.wdata[2:0] <= sleep_ctrl_pkg::MODE_MAX);
    wire period_ok   = (req.wdata[31:16] == 16'h0)
                    && (req.wdata[15:0] <= sleep_ctrl_pkg::PERIOD_MAX);
    wire idle_ok     = (req.wdata[31:16] == 16'h0)
                    && (req.wdata[15:0] >= sleep_ctrl_pkg::IDLE_TIME_MIN);
    wire wr_mode     = req.wr && sel_mode && mode_ok;
    wire wr_opts     = req.wr && sel_opts;
    wire wr_period   = req.wr && sel_period && period_ok;
    wire wr_idle     = req.wr && sel_idle && idle_ok;
    wire wr_ctrl     = req.wr && sel_ctrl;
    wire cfg_write   = wr_mode || wr_period || wr_idle;

    // Mode classes
    wire [2:0] mode  = cfg.sleep_mode_select;
    wire cyclic      = (mode == sleep_ctrl_pkg::MODE_CYCLIC)
                    || (mode == sleep_ctrl_pkg::MODE_CYCLIC_PIN);
    wire pin_mode    = (mode == sleep_ctrl_pkg::MODE_PIN_HIBERNATE)
                    || (mode == sleep_ctrl_pkg::MODE_PIN_DOZE);
    wire sleep_mode  = cyclic || pin_mode;
    // Period valid only in modes 4 to 6
    wire period_used = cyclic || (mode == sleep_ctrl_pkg::MODE_COORDINATOR);
    // Holding needs coordinator role and nonzero period
    wire coord_on    = period_used && (cfg.cyclic_sleep_period != 16'h0)
                    && ((mode == sleep_ctrl_pkg::MODE_COORDINATOR)
                        || cfg.coord_en);
    wire activity    = i_serial_activity || i_rf_activity;

    // Configuration registers
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg.sleep_mode_select      <= sleep_ctrl_pkg::SLEEP_MODE_RST;
            {cfg.sample_dis, cfg.poll_dis} <= sleep_ctrl_pkg::OPTIONS_RST;
            cfg.cyclic_sleep_period    <= sleep_ctrl_pkg::PERIOD_RST;
            cfg.idle_time_before_sleep <= sleep_ctrl_pkg::IDLE_TIME_RST;
            {cfg.coord_en, cfg.sample_en} <= sleep_ctrl_pkg::CONTROL_RST;
        end else begin
            if (wr_mode) begin
                cfg.sleep_mode_select <= req.wdata[2:0];
            end
            if (wr_opts) begin
                cfg.poll_dis   <= req.wdata[sleep_ctrl_pkg::OPT_POLL_DIS_BIT];
                cfg.sample_dis <=
                    req.wdata[sleep_ctrl_pkg::OPT_SAMPLE_DIS_BIT];
            end
            if (wr_period) begin
                cfg.cyclic_sleep_period <= req.wdata[15:0];
            end
            if (wr_idle) begin
                cfg.idle_time_before_sleep <= req.wdata[15:0];
            end
            if (wr_ctrl) begin
                cfg.sample_en <= req.wdata[sleep_ctrl_pkg::CTRL_SAMPLE_EN_BIT];
                cfg.coord_en  <= req.wdata[sleep_ctrl_pkg::CTRL_COORD_EN_BIT];
            end
        end
    end

    // Pin synchroniser
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= i_sleep_pin;
            pin_sync <= pin_meta;
        end
    end

    // Millisecond and ten millisecond ticks run freely
    interval_timer #(.WIDTH(17)) u_ms_prescale (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_load    (ms_tick || !ms_armed),
        .i_value   (17'(MS_CYCLES - 1)),
        .i_stop    (1'b0),
        .i_tick    (1'b1),
        .o_armed   (ms_armed),
        .o_expired (ms_tick)
    );

    // Free-running, so a sleep period may end up to one unit early
    interval_timer #(.WIDTH(4)) u_ten_prescale (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_load    (ten_tick || !ten_armed),
        .i_value   (4'(sleep_ctrl_pkg::MS_PER_PERIOD)),
        .i_stop    (1'b0),
        .i_tick    (ms_tick),
        .o_armed   (ten_armed),
        .o_expired (ten_tick)
    );

    wire enter_sleep = (state == sleep_ctrl_pkg::PS_AWAKE)
                    && (next_state == sleep_ctrl_pkg::PS_ASLEEP);
    wire waking      = state == sleep_ctrl_pkg::PS_WAKING;

    interval_timer #(.WIDTH(16)) u_idle_timer (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_load    (activity || cfg_write || waking),
        .i_value   (cfg.idle_time_before_sleep),
        .i_stop    (!cyclic),
        .i_tick    (ms_tick),
        .o_armed   (idle_armed),
        .o_expired (idle_done)
    );

    // Period counted in 10 ms ticks
    interval_timer #(.WIDTH(16)) u_period_timer (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_load    (enter_sleep && cyclic),
        .i_value   (cfg.cyclic_sleep_period),
        .i_stop    (!cyclic),
        .i_tick    (ten_tick),
        .o_armed   (period_armed),
        .o_expired (period_done)
    );

    // Hold time is 2.5 periods in ms
    wire [19:0] hold_ms = 20'(cfg.cyclic_sleep_period
                            * sleep_ctrl_pkg::HOLD_MS_PER_UNIT);

    interval_timer #(.WIDTH(sleep_ctrl_pkg::HOLD_W)) u_hold_timer (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_load    (i_msg_queued && coord_on),
        .i_value   (hold_ms),
        .i_stop    (i_msg_delivered || !coord_on),
        .i_tick    (ms_tick),
        .o_armed   (hold_armed),
        .o_expired (hold_done)
    );

    // Sleep state machine
    always_comb begin
        next_state = state;
        case (state)
            sleep_ctrl_pkg::PS_AWAKE: begin
                // Idle time used only in cyclic modes
                if (cyclic && idle_done && !activity) begin
                    next_state = sleep_ctrl_pkg::PS_ASLEEP;
                end else if (pin_mode && pin_sync) begin
                    next_state = sleep_ctrl_pkg::PS_ASLEEP;
                end
            end
            sleep_ctrl_pkg::PS_ASLEEP: begin
                if (!sleep_mode) begin
                    next_state = sleep_ctrl_pkg::PS_AWAKE;
                end else if (cyclic && period_done) begin
                    next_state = sleep_ctrl_pkg::PS_WAKING;
                end else if (mode == sleep_ctrl_pkg::MODE_CYCLIC_PIN
                             && !pin_sync) begin
                    next_state = sleep_ctrl_pkg::PS_WAKING;
                end else if (pin_mode && !pin_sync) begin
                    next_state = sleep_ctrl_pkg::PS_WAKING;
                end
            end
            sleep_ctrl_pkg::PS_WAKING: begin
                next_state = sleep_ctrl_pkg::PS_AWAKE;
            end
            default: begin
                next_state = sleep_ctrl_pkg::PS_AWAKE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= sleep_ctrl_pkg::PS_AWAKE;
        end else begin
            state <= next_state;
        end
    end

    // Held message flag; a new message wins over the clear
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_msg_held <= 1'b0;
        end else if (i_msg_queued && coord_on) begin
            o_msg_held <= 1'b1;
        end else if (hold_done || i_msg_delivered || !coord_on) begin
            o_msg_held <= 1'b0;
        end
    end

    assign o_msg_discard = hold_done && o_msg_held;
    assign o_sleep       = state == sleep_ctrl_pkg::PS_ASLEEP;
    assign o_deep_sleep  = o_sleep
                        && (mode == sleep_ctrl_pkg::MODE_PIN_HIBERNATE);
    // Poll on cyclic wake unless disabled
    assign o_poll_req    = waking && cyclic && !cfg.poll_dis;
    assign o_sample_req  = waking && cfg.sample_en && !cfg.sample_dis;

    // Read selection
    wire [31:0] status_word = 32'(
        (32'(state) << sleep_ctrl_pkg::STAT_STATE_LSB)
      | (32'(o_msg_held) << sleep_ctrl_pkg::STAT_HELD_BIT)
      | (32'(coord_on) << sleep_ctrl_pkg::STAT_COORD_BIT)
      | (32'(pin_sync) << sleep_ctrl_pkg::STAT_PIN_BIT));
    assign rd_word =
        sel_mode   ? {29'h0, cfg.sleep_mode_select} :
        sel_opts   ? {30'h0, cfg.sample_dis, cfg.poll_dis} :
        sel_period ? {16'h0, cfg.cyclic_sleep_period} :
        sel_idle   ? {16'h0, cfg.idle_time_before_sleep} :
        sel_ctrl   ? {30'h0, cfg.coord_en, cfg.sample_en} :
        sel_status ? status_word : 32'h0;

    // Read data stands for one cycle only
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_reg_rdata <= 32'h0;
        end else begin
            o_reg_rdata <= req.rd ? rd_word : 32'h0;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    property p_mode_range;
        mode <= sleep_ctrl_pkg::MODE_MAX;
    endproperty
    a_mode_range: assert property (p_mode_range)
        else $error("Sleep mode out of range");

    property p_disabled_awake;
        (mode == sleep_ctrl_pkg::MODE_DISABLED) [*2] |-> !o_sleep;
    endproperty
    a_disabled_awake: assert property (p_disabled_awake)
        else $error("Asleep while sleep is disabled");

    property p_poll_on_wake;
        (o_sleep && period_done && cyclic && !cfg.poll_dis && !req.wr)
            |=> o_poll_req ##1 !o_poll_req;
    endproperty
    a_poll_on_wake: assert property (p_poll_on_wake)
        else $error("Missing single poll after cyclic wake");

    property p_sample_cause;
        o_sample_req |-> cfg.sample_en && !cfg.sample_dis
                         && $past(o_sleep);
    endproperty
    a_sample_cause: assert property (p_sample_cause)
        else $error("Wake sample without cause");

    property p_period_wake;
        (o_sleep && period_done && cyclic && !req.wr)
            |=> (state == sleep_ctrl_pkg::PS_WAKING)
                ##1 (state == sleep_ctrl_pkg::PS_AWAKE);
    endproperty
    a_period_wake: assert property (p_period_wake)
        else $error("No wake after sleep period");

    property p_period_range;
        cfg.cyclic_sleep_period <= sleep_ctrl_pkg::PERIOD_MAX;
    endproperty
    a_period_range: assert property (p_period_range)
        else $error("Sleep period above maximum");

    property p_pin_ignores_period;
        (o_sleep && pin_mode && pin_sync && !req.wr) |=> o_sleep;
    endproperty
    a_pin_ignores_period: assert property (p_pin_ignores_period)
        else $error("Pin sleep ended without pin release");

    property p_hold_drop;
        (o_msg_held && !coord_on && !$past(i_msg_queued)) |=> !o_msg_held;
    endproperty
    a_hold_drop: assert property (p_hold_drop)
        else $error("Message held outside coordinator role");

    property p_idle_min;
        cfg.idle_time_before_sleep >= sleep_ctrl_pkg::IDLE_TIME_MIN;
    endproperty
    a_idle_min: assert property (p_idle_min)
        else $error("Idle time below minimum");

    property p_cyclic_entry;
        (state == sleep_ctrl_pkg::PS_AWAKE && cyclic) ##1 o_sleep
            |-> $past(idle_done) && !$past(activity);
    endproperty
    a_cyclic_entry: assert property (p_cyclic_entry)
        else $error("Cyclic sleep without idle expiry");

    property p_pin_awake;
        (pin_mode && !o_sleep && !pin_sync && !req.wr) |=> !o_sleep;
    endproperty
    a_pin_awake: assert property (p_pin_awake)
        else $error("Pin mode slept on idle time");

    c_cyclic_sleep: cover property (cyclic && enter_sleep);
    c_wake_poll:    cover property (o_poll_req);
    c_discard:      cover property (o_msg_discard);
    c_hibernate:    cover property (o_deep_sleep);

endmodule : sleep_mode_controller

/* sleep_mode_controller_tb_top.sv */
// Self-checking bench of the sleep mode controller
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module sleep_mode_controller_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC = 20;
    logic        clk, resetn, wr, rd, ser, rf, pin, mq, dlv;
    logic        slp, deep, poll, smp, held, disc, s, acc;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, d, m, w;
    int          fail_count, checked, cycles, seed, i, n;

    host_bus_model host_u (.i_ref_clk(clk), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

    sleep_mode_controller #(.MS_CYCLES(MSC)) dut_u (.i_ref_clk(clk),
        .i_resetn(resetn), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .i_serial_activity(ser), .i_rf_activity(rf), .i_data_pending(1'b0),
        .i_sleep_pin(pin), .i_msg_queued(mq), .i_msg_delivered(dlv),
        .o_sleep(slp), .o_deep_sleep(deep), .o_poll_req(poll),
        .o_sample_req(smp), .o_msg_held(held), .o_msg_discard(disc));

    function automatic logic [31:0] rst_val(input int k);
        return (k == 3) ? 32'h3e8 : 32'h0;
    endfunction : rst_val

    function automatic logic [31:0] next_mode(input logic [31:0] c, v);
        return (v <= 32'h6) ? v : c;
    endfunction : next_mode

    task automatic close_out();
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    // Collects whether the block slept during k cycles
    task automatic watch(input int k);
        s = 1'b0;
        repeat (k) begin
            @(posedge clk);
            #1;
            s = s | slp;
        end
    endtask : watch

    task automatic wait_lvl(input logic v);
        #1;
        for (n = 0; n < 600 && slp !== v; n++) begin
            @(posedge clk);
            #1;
        end
        `CHK(slp, v)
    endtask : wait_lvl

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            close_out();
        end
    end

    initial begin
        seed = 646;
        {resetn, ser, rf, pin, mq, dlv} = 6'h0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        for (i = 0; i < 7; i++) begin
            host_u.rd(8'(i * 4), d);
            `CHK(d, rst_val(i))
        end
        m = 32'h0;
        repeat (12) begin
            w = {29'h0, 3'($random(seed))};
            host_u.wr(8'h00, w);
            m = next_mode(m, w);
            host_u.rd(8'h00, d);
            `CHK(d, m)
        end
        host_u.wr(8'h08, 32'h68b1);
        host_u.wr(8'h08, 32'h68b0);
        host_u.wr(8'h0c, 32'h0);
        host_u.rd(8'h08, d);
        `CHK(d, 32'h68b0)
        host_u.rd(8'h0c, d);
        `CHK(d, 32'h3e8)
        host_u.wr(8'h08, 32'h1);
        host_u.wr(8'h0c, 32'h1);
        for (i = 0; i < 3; i++) begin
            host_u.wr(8'h00, (i == 0) ? 32'h0 : 32'(i * 3));
            watch(300);
            `CHK(s, 1'b0)
        end
        host_u.wr(8'h10, 32'h1);
        host_u.wr(8'h00, 32'h4);
        for (i = 0; i < 4; i++) begin
            host_u.wr(8'h04, 32'(i));
            wait_lvl(1'b1);
            wait_lvl(1'b0);
            `CHK(poll, ~i[0])
            `CHK(smp, ~i[1])
        end
        host_u.wr(8'h0c, 32'h2);
        acc = 1'b0;
        repeat (12) begin
            @(posedge clk);
            w = $random(seed);
            ser <= w[0];
            rf <= ~w[0];
            @(posedge clk);
            {ser, rf} <= 2'h0;
            // Gap under one ms, as the free prescaler may cut the idle time
            watch(16);
            acc = acc | s;
        end
        `CHK(acc, 1'b0)
        wait_lvl(1'b1);
        for (i = 1; i < 3; i++) begin
            host_u.wr(8'h00, 32'(i));
            wait_lvl(1'b0);
            pin <= 1'b1;
            wait_lvl(1'b1);
            `CHK(deep, (i == 1))
            pin <= 1'b0;
            wait_lvl(1'b0);
        end
        host_u.wr(8'h00, 32'h6);
        for (i = 1; i >= 0; i--) begin
            host_u.wr(8'h08, 32'(i));
            @(posedge clk);
            mq <= 1'b1;
            @(posedge clk);
            mq <= 1'b0;
            #1;
            `CHK(held, (i == 1))
        end
        host_u.wr(8'h08, 32'h1);
        @(posedge clk);
        mq <= 1'b1;
        @(posedge clk);
        {mq, dlv} <= 2'h1;
        @(posedge clk);
        dlv <= 1'b0;
        #1;
        `CHK(held, 1'b0)
        @(posedge clk);
        mq <= 1'b1;
        @(posedge clk);
        mq <= 1'b0;
        for (n = 0; n < 600 && disc !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        `CHK((n >= 480 && n <= 520), 1'b1)
        close_out();
    end
endmodule : sleep_mode_controller_tb_top
